// *** core/opdec_pkg.sv ***
// Purpose: shared constants and types of the upper opcode map decoder
// Assumes: one opcode byte per fetch, operands presented alongside
// Notes: byte lengths cover the arithmetic groups, single-operand ops, C5 and short branches

package opdec_pkg;

   // =====================================================
   // widths
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned LEN_W = 3;
   localparam int unsigned REL_W = 11;

   // =====================================================
   // special opcodes
   localparam logic [7:0] OPC_RSV_QUIET = 8'hee;
   localparam logic [7:0] OPC_RSV_IRQ_LO = 8'hec;
   localparam logic [7:0] OPC_RSV_IRQ_HI = 8'hed;
   localparam logic [7:0] OPC_SIGNED_PREFIX = 8'hfe;
   localparam logic [7:0] OPC_IND_BRANCH = 8'he3;
   localparam logic [7:0] OPC_CMPL = 8'hc5;
   localparam logic [4:0] OPC_SJ_TOP = 5'h04;
   localparam logic [4:0] OPC_SC_TOP = 5'h05;
   localparam logic [1:0] OPC_MULDIV_LOW = 2'h3;
   localparam logic [3:0] ROW_MUL3_W = 4'h4;
   localparam logic [3:0] ROW_MUL3_B = 4'h5;
   localparam logic [3:0] ROW_MUL2_W = 4'h6;
   localparam logic [3:0] ROW_MUL2_B = 4'h7;
   localparam logic [3:0] ROW_DIV_W = 4'h8;
   localparam logic [3:0] ROW_DIV_B = 4'h9;
   localparam logic [3:0] ROW_ADDC_W = 4'ha;
   localparam logic [3:0] ROW_ADDC_B = 4'hb;
   localparam logic [2:0] ROW_3OP_TOP = 3'h2;
   localparam logic [1:0] OPC_SUB_PAIR = 2'h2;

   // =====================================================
   // byte counts
   localparam logic [LEN_W-1:0] LEN_SINGLE = 3'h2;
   localparam logic [LEN_W-1:0] LEN_2OP = 3'h3;
   localparam logic [LEN_W-1:0] LEN_3OP = 3'h4;
   localparam logic [LEN_W-1:0] LEN_SHORT_BR = 3'h2;
   localparam logic [LEN_W-1:0] LEN_CMPL = 3'h3;
   localparam logic [LEN_W-1:0] LEN_ONE = 3'h1;
   localparam logic [LEN_W-1:0] LEN_NONE = 3'h0;

   // bit of the first operand byte that picks the long index form
   localparam int unsigned IDX_LONG_BIT = 0;

   // =====================================================
   // types
   typedef enum logic [1:0] {
      AM_DIRECT = 2'b00,
      AM_IMMEDIATE = 2'b01,
      AM_INDIRECT = 2'b10,
      AM_INDEXED = 2'b11
   } addr_mode_t;

   typedef enum logic [3:0] {
      OC_OTHER = 4'b0000,
      OC_ARITH = 4'b0001,
      OC_BYTE_SUBTRACT = 4'b0010,
      OC_WORD_MUL_MAC = 4'b0011,
      OC_UNSIGNED_BYTE_MULTIPLY = 4'b0100,
      OC_UNSIGNED_WORD_DIVIDE = 4'b0101,
      OC_UNSIGNED_BYTE_DIVIDE = 4'b0110,
      OC_SHORT_RELATIVE_JUMP = 4'b0111,
      OC_SHORT_RELATIVE_CALL = 4'b1000,
      OC_INDIRECT_BRANCH_16 = 4'b1001,
      OC_EXTENDED_INDIRECT_BRANCH = 4'b1010,
      OC_RESERVED = 4'b1011,
      OC_SINGLE_DIRECT = 4'b1100
   } op_class_t;

   typedef enum logic {
      ST_PLAIN = 1'b0,
      ST_PREFIXED = 1'b1
   } prefix_state_t;

   typedef struct packed {
      logic [BYTE_W-1:0] opcode;
      logic [BYTE_W-1:0] opnd1;
      logic dest_lsb;
   } fetch_t;

   typedef struct packed {
      op_class_t op_class;
      addr_mode_t mode;
      logic mode_valid;
      logic [LEN_W-1:0] length;
      logic is_signed;
      logic prefixed;
      logic [REL_W-1:0] rel_offset;
      logic reserved;
      logic mac_round_ok;
   } dec_info_t;

   localparam dec_info_t DEC_INFO_RESET = '{
      op_class: OC_OTHER, mode: AM_DIRECT, mode_valid: 1'b0,
      length: LEN_NONE, is_signed: 1'b0, prefixed: 1'b0,
      rel_offset: 11'h000, reserved: 1'b0, mac_round_ok: 1'b0};

endpackage

// *** core/opdec_len.sv ***
// Purpose: instruction byte length for arithmetic groups and branches
// Assumes: opcode and long-index flag are valid together
// Notes: unknown opcodes report length zero with known low

`timescale 1ns/10ps
`default_nettype none

module opdec_len
   import opdec_pkg::*;
(
   // opcode and qualifiers
   input wire logic [7:0] opcode,
   input wire logic long_idx,
   input wire logic prefixed,
   // result
   output logic [2:0] len,
   output logic known
);

   // =====================================================
   // row decode
   wire [3:0] row = opcode[7:4];
   wire [1:0] am = opcode[1:0];
   wire low_arith = (opcode[7:6] == 2'b01);
   wire mid_arith = (row == ROW_DIV_W) || (row == ROW_DIV_B);
   wire carry_rows = ((row == ROW_ADDC_W) || (row == ROW_ADDC_B))
      && (opcode[3:2] != 2'b00) && (opcode[3:2] != 2'b11);
   wire arith = low_arith || mid_arith || carry_rows;
   wire three_op = (opcode[7:5] == ROW_3OP_TOP);
   wire is_word = ~opcode[4];
   wire single = (opcode[7:5] == 3'b000) && (opcode[3] == 1'b0)
      && ((opcode[2:0] == 3'h1) || (opcode[2:0] >= 3'h5));
   wire short_br = (opcode[7:3] == OPC_SJ_TOP)
      || (opcode[7:3] == OPC_SC_TOP) || (opcode == OPC_IND_BRANCH);

   // =====================================================
   // arithmetic length: base, wide immediate, index, prefix
   wire [2:0] base = three_op ? LEN_3OP : LEN_2OP;
   wire [2:0] imm_add = (am == AM_IMMEDIATE && is_word) ? LEN_ONE
      : LEN_NONE;
   wire [2:0] idx_add = (am == AM_INDEXED) ?
      (long_idx ? LEN_SHORT_BR : LEN_ONE) : LEN_NONE;
   wire [2:0] pfx_add = prefixed ? LEN_ONE : LEN_NONE;
   wire [2:0] arith_len = 3'(base + imm_add + idx_add + pfx_add);

   assign len = arith ? arith_len
      : single ? LEN_SINGLE
      : (opcode == OPC_CMPL) ? LEN_CMPL
      : short_br ? LEN_SHORT_BR
      : LEN_NONE;
   assign known = arith || single || short_br || (opcode == OPC_CMPL);

endmodule

`default_nettype wire

// *** core/opcode_decode_upper_map.sv ***
// Purpose: decode opcode bytes into class, mode, length and sign
// Assumes: the fetch unit presents one opcode with the bytes after it
// Notes: one decode per accepted opcode except the FE prefix, answer one clock later
//
// Functional notes
// - EE is reserved and raises no interrupt
// - E3 branches 16-bit or extended per mode
// - destination bit zero selects signed multiply/divide
// - FE prefix selects signed, one byte longer
// - signed and unsigned share one opcode
// - short jump/call offset is eleven-bit two's complement
// - two low opcode bits select addressing mode
// - long indexed form is one byte longer
// - length per operation and mode, word immediate wider
// - not-applicable modes are unsupported
// - multiply-accumulate shares the word multiply opcodes

`timescale 1ns/10ps
`default_nettype none

module opcode_decode_upper_map
   import opdec_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_B,
   // fetch side
   input wire logic FETCH_VALID,
   input wire opdec_pkg::fetch_t FETCH,
   input wire logic MODE_1MB,
   // decode result
   output logic DEC_VALID,
   output opdec_pkg::dec_info_t DEC_INFO,
   output logic UNIMPL_IRQ
);
   import opdec_pkg::*;

   // =====================================================
   // fields of the fetched opcode
   wire [7:0] op = FETCH.opcode;
   wire [3:0] row = op[7:4];
   wire [1:0] low2 = op[1:0];
   wire [1:0] col = op[3:2];

   // =====================================================
   // prefix tracking
   prefix_state_t state_reg;
   prefix_state_t state_next;
   wire is_prefix = (op == OPC_SIGNED_PREFIX);

   // =====================================================
   // multiply and divide columns
   wire muldiv_col = (col == OPC_MULDIV_LOW);
   wire word_mul = muldiv_col
      && ((row == ROW_MUL3_W) || (row == ROW_MUL2_W));
   wire byte_mul = muldiv_col
      && ((row == ROW_MUL3_B) || (row == ROW_MUL2_B));
   wire word_div = muldiv_col && (row == ROW_DIV_W);
   wire byte_div = muldiv_col && (row == ROW_DIV_B);
   wire muldiv = word_mul || byte_mul || word_div || byte_div;

   // a prefix only counts when it lands on a multiply or divide
   wire pfx_applies = (state_reg == ST_PREFIXED) && muldiv;
   wire signed_op = muldiv
      && (FETCH.dest_lsb || pfx_applies);

   // =====================================================
   // other classes
   wire byte_sub = (col == OPC_SUB_PAIR)
      && ((row == ROW_MUL3_B) || (row == ROW_MUL2_B));
   wire sjump = (op[7:3] == OPC_SJ_TOP);
   wire short_relative_call = (op[7:3] == OPC_SC_TOP);
   wire ind_br = (op == OPC_IND_BRANCH);
   wire rsv_quiet = (op == OPC_RSV_QUIET);
   wire rsv_irq = (op == OPC_RSV_IRQ_LO)
      || (op == OPC_RSV_IRQ_HI);
   wire single = (op[7:5] == 3'b000) && (op[3] == 1'b0)
      && ((op[2:0] == 3'h1) || (op[2:0] >= 3'h5));

   // arithmetic and logic rows where the low bits carry the mode
   wire low_rows = (op[7:6] == 2'b01);
   wire mid_rows = (row == ROW_DIV_W) || (row == ROW_DIV_B);
   wire carry_rows = ((row == ROW_ADDC_W) || (row == ROW_ADDC_B))
      && (col != 2'b00) && (col != 2'b11);
   wire mode_rows = low_rows || mid_rows || carry_rows;

   // =====================================================
   // class selection
   wire op_class_t cls =
      rsv_quiet || rsv_irq ? OC_RESERVED
      : ind_br ? (MODE_1MB ? OC_EXTENDED_INDIRECT_BRANCH
         : OC_INDIRECT_BRANCH_16)
      : sjump ? OC_SHORT_RELATIVE_JUMP
      : short_relative_call ? OC_SHORT_RELATIVE_CALL
      : word_mul ? OC_WORD_MUL_MAC
      : byte_mul ? OC_UNSIGNED_BYTE_MULTIPLY
      : word_div ? OC_UNSIGNED_WORD_DIVIDE
      : byte_div ? OC_UNSIGNED_BYTE_DIVIDE
      : byte_sub ? OC_BYTE_SUBTRACT
      : single ? OC_SINGLE_DIRECT
      : mode_rows ? OC_ARITH
      : OC_OTHER;

   // =====================================================
   // addressing mode
   // single-operand ops only exist in direct form
   wire addr_mode_t mode = single ? AM_DIRECT
      : addr_mode_t'(low2);
   wire mode_valid = mode_rows || single;

   // rounding accumulate has no immediate form; the variant
   // itself is picked by bytes beyond the opcode
   wire round_ok = word_mul && (mode != AM_IMMEDIATE);

   // =====================================================
   // relative offset of short jump and call
   wire [10:0] rel = (sjump || short_relative_call) ?
      {op[2:0], FETCH.opnd1} : 11'h000;

   // =====================================================
   // length
   wire [2:0] len;
   wire len_known;

   opdec_len u_len (
      .opcode(op),
      .long_idx(FETCH.opnd1[IDX_LONG_BIT]),
      .prefixed(pfx_applies),
      .len(len),
      .known(len_known)
   );

   // length is only meaningful where the table defines one
   wire [2:0] len_out = len_known ? len : LEN_NONE;

   // =====================================================
   // assembled decode word
   dec_info_t info_next;

   always_comb begin
      info_next = DEC_INFO_RESET;
      info_next.op_class = cls;
      info_next.mode = mode;
      info_next.mode_valid = mode_valid;
      info_next.length = len_out;
      info_next.is_signed = signed_op;
      info_next.prefixed = pfx_applies;
      info_next.rel_offset = rel;
      info_next.reserved = rsv_quiet || rsv_irq;
      info_next.mac_round_ok = round_ok;
   end

   // =====================================================
   // prefix state machine
   always_comb begin
      state_next = state_reg;
      if (FETCH_VALID) begin
         case (state_reg)
            ST_PLAIN: begin
               if (is_prefix) begin
                  state_next = ST_PREFIXED;
               end
            end
            ST_PREFIXED: begin
               // a repeated prefix keeps it pending
               if (!is_prefix) begin
                  state_next = ST_PLAIN;
               end
            end
            default: begin
               state_next = ST_PLAIN;
            end
         endcase
      end
   end

   // =====================================================
   // outputs
   wire valid_next = FETCH_VALID && !is_prefix;
   wire irq_next = FETCH_VALID && rsv_irq;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         state_reg <= ST_PLAIN;
         DEC_VALID <= 1'b0;
         DEC_INFO <= DEC_INFO_RESET;
         UNIMPL_IRQ <= 1'b0;
      end else begin
         state_reg <= state_next;
         DEC_VALID <= valid_next;
         UNIMPL_IRQ <= irq_next;
         if (valid_next) begin
            DEC_INFO <= info_next;
         end
      end
   end

endmodule

`default_nettype wire

// *** dv/opdec_asserts.sv ***
// Purpose: port assertions for the upper opcode map decoder
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the decoder top module

`timescale 1ns/10ps
`default_nettype none

module opdec_asserts (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_B,
   // fetch side
   input wire logic FETCH_VALID,
   input wire opdec_pkg::fetch_t FETCH,
   input wire logic MODE_1MB,
   // decode result
   input wire logic DEC_VALID,
   input wire opdec_pkg::dec_info_t DEC_INFO,
   input wire logic UNIMPL_IRQ
);
   import opdec_pkg::*;
   // =======
   // properties
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   wire logic tk = FETCH_VALID;
   wire logic [7:0] op = FETCH.opcode;

   quiet_rsv_a:
      assert property (tk && op == 8'hee |=> DEC_VALID && DEC_INFO.reserved
         && !UNIMPL_IRQ) else $error("EE decode wrong");
   unimpl_irq_a:
      assert property (UNIMPL_IRQ == $past(tk && op inside {8'hec, 8'hed}))
      else $error("irq pulse wrong");
   prefix_out_a:
      assert property (DEC_VALID == $past(tk && op != 8'hfe))
      else $error("decode pulse wrong");
   branch_mode_a:
      assert property (tk && op == 8'he3 |=> DEC_INFO.op_class ==
         ($past(MODE_1MB) ? OC_EXTENDED_INDIRECT_BRANCH
         : OC_INDIRECT_BRANCH_16)) else $error("branch class wrong");
   sign_dest_a:
      assert property (tk && op[7:4] inside {[4'h4:4'h9]} && op[3:2] == 2'b11
         && FETCH.dest_lsb |=> DEC_INFO.is_signed) else $error("not signed");
   rel_offset_a:
      assert property (tk && op[7:4] == 4'h2 |=> DEC_INFO.rel_offset ==
         $past({op[2:0], FETCH.opnd1})) else $error("offset wrong");
   mode_bits_a:
      assert property (tk && op[7:6] == 2'b01 && op[3:2] != 2'b00 |=>
         DEC_INFO.mode == $past(op[1:0])) else $error("mode wrong");
   long_idx_a:
      assert property (tk && op == 8'h67 |=> DEC_INFO.length ==
         ($past(FETCH.opnd1[0]) ? 3'h5 : 3'h4)) else $error("index length");
   imm_len_a:
      assert property (tk && op inside {8'h65, 8'h75} |=> DEC_INFO.length ==
         ($past(op[4]) ? 3'h3 : 3'h4)) else $error("immediate length");
   mac_round_a:
      assert property (tk && op inside {8'h4c, 8'h4d, 8'h6c, 8'h6d} |=>
         DEC_INFO.op_class == OC_WORD_MUL_MAC && DEC_INFO.mac_round_ok ==
         $past(op[1:0] != 2'b01)) else $error("mac decode wrong");
endmodule

bind opcode_decode_upper_map opdec_asserts chk (.CLK_SYS(CLK_SYS),
   .RST_B(RST_B), .FETCH_VALID(FETCH_VALID), .FETCH(FETCH),
   .MODE_1MB(MODE_1MB), .DEC_VALID(DEC_VALID), .DEC_INFO(DEC_INFO),
   .UNIMPL_IRQ(UNIMPL_IRQ));

`default_nettype wire

// *** dv/fetch_model.sv ***
// Purpose: program memory and fetch unit stand-in
// Assumes: bench requests one byte set per cycle
// Notes: bytes change only at the falling edge

`timescale 1ns/10ps
`default_nettype none

module fetch_model (
   // clock
   input wire logic CLK_SYS,
   // request from the bench
   input wire logic req,
   input wire opdec_pkg::fetch_t cmd,
   // fetch side
   output var logic FETCH_VALID,
   output var opdec_pkg::fetch_t FETCH
);
   import opdec_pkg::*;
   // =======
   // drive
   initial begin
      FETCH_VALID = 1'b0;
      FETCH = '0;
   end
   // idle cycles show inverted bytes so a stale value never looks valid
   always @(negedge CLK_SYS) begin
      FETCH_VALID <= req;
      FETCH <= req ? cmd : ~FETCH;
   end
endmodule

`default_nettype wire

// *** dv/opcode_decode_upper_map_tb_top.sv ***
// Purpose: self-checking bench for the upper opcode map decoder
// Assumes: answer one clock after the taken edge
// Notes: each scenario drives and judges on its own

`timescale 1ns/10ps
`default_nettype none

module opcode_decode_upper_map_tb_top;
   import opdec_pkg::*;
   // =======
   // clock, reset and wiring
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic mode_1mb = 1'b0;
   logic req = 1'b0;
   fetch_t cmd = '0;
   logic fetch_valid;
   fetch_t fetch;
   logic dec_valid;
   logic unimpl_irq;
   dec_info_t info;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   always #4 clk_sys = ~clk_sys;

   fetch_model fm (.CLK_SYS(clk_sys), .req(req), .cmd(cmd),
      .FETCH_VALID(fetch_valid), .FETCH(fetch));
   opcode_decode_upper_map dut (.CLK_SYS(clk_sys), .RST_B(rst_b),
      .FETCH_VALID(fetch_valid), .FETCH(fetch), .MODE_1MB(mode_1mb),
      .DEC_VALID(dec_valid), .DEC_INFO(info), .UNIMPL_IRQ(unimpl_irq));

   // =======
   // shared tasks
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end

   // last=1 ends at the falling edge where the one-cycle answer stands
   task automatic issue(input logic [7:0] op, input logic [7:0] b1,
                        input logic dl, input bit last);
      @(posedge clk_sys);
      req <= 1'b1;
      cmd <= '{opcode: op, opnd1: b1, dest_lsb: dl};
      if (last) begin
         @(posedge clk_sys);
         req <= 1'b0;
         @(negedge clk_sys);
      end
   endtask

   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic look(input op_class_t c, input logic [2:0] len);
      chk(dec_valid, 1'b1);
      chk(info.op_class, c);
      chk(info.length, len);
   endtask

   // =======
   // scenarios
   task automatic t_reserved;
      issue(8'hee, 8'h00, 1'b0, 1'b1);
      chk(unimpl_irq, 1'b0);
      chk(info.reserved, 1'b1);
      for (int i = 0; i < 2; i++) begin
         issue(8'hec + 8'(i), 8'h00, 1'b0, 1'b1);
         chk(unimpl_irq, 1'b1);
      end
      $display("reserved done");
   endtask

   task automatic t_branch;
      for (int m = 0; m < 2; m++) begin
         @(negedge clk_sys);
         mode_1mb = m[0];
         issue(8'he3, 8'h04, 1'b0, 1'b1);
         chk(info.op_class, m[0] ? OC_EXTENDED_INDIRECT_BRANCH
            : OC_INDIRECT_BRANCH_16);
         chk(info.mode_valid, 1'b0);
      end
      $display("branch done");
   endtask

   task automatic t_muldiv;
      issue(8'h8c, 8'h00, 1'b1, 1'b1);
      look(OC_UNSIGNED_WORD_DIVIDE, 3'h3);
      chk(info.is_signed, 1'b1);
      issue(8'h9f, 8'h01, 1'b0, 1'b1);
      look(OC_UNSIGNED_BYTE_DIVIDE, 3'h5);
      chk(info.is_signed, 1'b0);
      issue(8'h7c, 8'h00, 1'b1, 1'b1);
      look(OC_UNSIGNED_BYTE_MULTIPLY, 3'h3);
      $display("muldiv done");
   endtask

   task automatic t_prefix;
      issue(8'hfe, 8'h00, 1'b0, 1'b0);
      issue(8'h6f, 8'h01, 1'b0, 1'b1);
      look(OC_WORD_MUL_MAC, 3'h6);
      chk(info.prefixed & info.is_signed, 1'b1);
      issue(8'hfe, 8'h00, 1'b0, 1'b0);
      issue(8'h65, 8'h00, 1'b0, 1'b1);
      chk(info.length, 3'h4);
      chk(info.prefixed, 1'b0);
      $display("prefix done");
   endtask

   task automatic t_short;
      issue(8'h27, 8'hff, 1'b0, 1'b1);
      chk(info.rel_offset, 11'h7ff);
      issue(8'h28, 8'h80, 1'b0, 1'b1);
      chk(info.rel_offset, 11'h080);
      chk(info.op_class, OC_SHORT_RELATIVE_CALL);
      $display("short done");
   endtask

   task automatic t_modes;
      for (int i = 0; i < 4; i++) begin
         issue(8'h78 + 8'(i), 8'h00, 1'b0, 1'b1);
         look(OC_BYTE_SUBTRACT, i == 3 ? 3'h4 : 3'h3);
         chk(info.mode, 11'(i));
         chk(info.mode_valid, 1'b1);
      end
      $display("modes done");
   endtask

   task automatic t_len;
      for (int l = 0; l < 2; l++) begin
         issue(8'h67, 8'(l), 1'b0, 1'b1);
         look(OC_ARITH, 3'h4 + 3'(l));
         issue(8'h47, 8'(l), 1'b0, 1'b1);
         look(OC_ARITH, 3'h5 + 3'(l));
      end
      issue(8'h65, 8'h00, 1'b0, 1'b1);
      chk(info.length, 3'h4);
      issue(8'h75, 8'h00, 1'b0, 1'b1);
      chk(info.length, 3'h3);
      issue(8'hc5, 8'h00, 1'b0, 1'b1);
      look(OC_OTHER, 3'h3);
      $display("length done");
   endtask

   task automatic t_mac;
      issue(8'h4d, 8'h00, 1'b0, 1'b1);
      look(OC_WORD_MUL_MAC, 3'h5);
      chk(info.mac_round_ok, 1'b0);
      issue(8'h6e, 8'h00, 1'b0, 1'b1);
      chk(info.mac_round_ok, 1'b1);
      issue(8'h06, 8'h00, 1'b0, 1'b1);
      look(OC_SINGLE_DIRECT, 3'h2);
      chk(info.mode, AM_DIRECT);
      chk(info.mode_valid, 1'b1);
      $display("mac done");
   endtask

   // reset in mid-run must also drop a pending prefix
   task automatic t_reset;
      issue(8'hfe, 8'h00, 1'b0, 1'b0);
      @(posedge clk_sys);
      req <= 1'b0;
      @(negedge clk_sys);
      rst_b = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(dec_valid, 1'b0);
      chk(unimpl_irq, 1'b0);
      chk(info === DEC_INFO_RESET, 1'b1);
      rst_b = 1'b1;
      issue(8'h6c, 8'h00, 1'b0, 1'b1);
      look(OC_WORD_MUL_MAC, 3'h3);
      chk(info.prefixed | info.is_signed, 1'b0);
      $display("reset done");
   endtask

   initial begin
      repeat (12) @(negedge clk_sys);
      rst_b = 1'b1;
      t_reserved();
      t_branch();
      t_muldiv();
      t_prefix();
      t_short();
      t_modes();
      t_len();
      t_mac();
      t_reset();
      end_sim();
   end
endmodule

`default_nettype wire
